/* rtl/cts_core.sv */
// core sequencer, reduced alu and reset-state register file
// assumes synchronous program memory data by phase 3, apb master
// Behaviour
// (RL1) a machine cycle is exactly four system clocks
// (RL2) at most one code byte fetched per machine cycle
// (RL3) instructions keep standard semantics with this core's own cycle counts
// (RL4) inc and dec leave carry, overflow, auxiliary carry alone
// (RL5) add, addc, subb set all three; da, rotates, compare_jump_not_equal, carry ops carry only
// (RL6) mul and div clear carry, set overflow; setb/clr force carry
// (RL7) compare-jump-not-equal B4..BF: three bytes, four machine cycles
// (RL8) any reset: acc, b, status, psw to 00h, stack pointer 07h
// (RL9) any reset: both data pointers and select to 00h
// (RL10) any reset: five port latches and directions to ffh
// (RL11) any reset: interrupt, extended and high byte registers to 00h
// (RL12) any reset: clock controls, serial control and buffer to 00h
// (RL13) any reset: caller-id registers to 00h
// (RL14) fsk and tone data read the live detector state
// (RL15) all resets load the same values except power and watchdog regs
// (RL16) watchdog reset keeps power reg top three bits; others load 81h
// (RL17) watchdog reset sets reset flag; power-on clears; external keeps
// (RL18) power-on sets power-on flag, clears reset enable
`timescale 1ns/1ps
`default_nettype none
module cts_core (
  // clock and reset (reset is the power-on reset)
  input wire logic clk,
  input wire logic reset,
  // other reset sources
  input wire logic ext_rst_req,
  input wire logic wdt_rst_req,
  // program memory
  output logic [15:0] code_addr,
  output logic code_rd,
  input wire logic [7:0] code_data,
  // detection circuits
  input wire logic [7:0] fsk_detect,
  input wire logic [7:0] tone_detect,
  // ports
  output logic [cts_pkg::NPORT-1:0][7:0] port_latch,
  output logic [cts_pkg::NPORT-1:0][7:0] port_dir,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import cts_pkg::*;

  logic sreset;
  logic mc_end;
  logic fetch_need;
  logic [1:0] phase_q;
  cts_state_t st_q;
  logic [7:0] op_q, a1_q, a2_q;
  logic [1:0] bytes_left_q;
  logic [2:0] mc_left_q;
  logic idx_q;
  logic exec_q;
  logic [15:0] pc_q;
  logic [4:0] len;
  logic run_q;
  logic [7:0] acc_q, b_q, psw_q, sp_q, dps_q, pmr_q, watchdog_control_reg_q;
  logic [7:0] dp_q [4];
  logic [7:0] r_q [8];
  logic [7:0] misc_q [NMISC];
  logic [NPORT-1:0][7:0] port_q, dir_q;
  logic [7:0] acc_d, b_d, psw_d, lhs, rhs;
  logic [8:0] s9;
  logic [4:0] lo5;
  logic [15:0] prod;
  logic cin, br, rw_en;
  logic wr, rd_hit, err_q;
  logic [15:0] rd_val, rd_q;

  assign sreset = ext_rst_req | wdt_rst_req;
  assign mc_end = phase_q == PH_LAST;
  assign fetch_need = st_q == ST_OPC || bytes_left_q != 2'h0;
  assign code_rd = phase_q == PH_FETCH && fetch_need; // RL2
  assign code_addr = pc_q;
  assign port_latch = port_q;
  assign port_dir = dir_q;

  function automatic logic [4:0] op_len(input logic [7:0] o);
    if (o >= OP_COMPARE_JUMP_NOT_EQUAL_AI && o <= OP_COMPARE_JUMP_NOT_EQUAL_HI) return LEN_3_4; // RL7
    if (o == OP_MUL || o == OP_DIV) return LEN_1_5;
    if (o == OP_ADDI || o == OP_ADDCI || o == OP_SUBBI || o == OP_MOVAI) return LEN_2_2;
    if (o[7:3] == OP_MOVRI[7:3]) return LEN_2_2;
    return LEN_1_1;
  endfunction
  assign len = op_len(code_data);

  // machine-cycle sequencer and fetch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_q <= PH_FIRST;
      st_q <= ST_OPC;
      op_q <= ZERO8;
      a1_q <= ZERO8;
      a2_q <= ZERO8;
      bytes_left_q <= 2'h0;
      mc_left_q <= 3'h0;
      idx_q <= 1'b0;
      exec_q <= 1'b0;
      pc_q <= 16'h0000;
    end else if (sreset) begin
      phase_q <= PH_FIRST;
      st_q <= ST_OPC;
      op_q <= ZERO8;
      bytes_left_q <= 2'h0;
      mc_left_q <= 3'h0;
      idx_q <= 1'b0;
      exec_q <= 1'b0;
      pc_q <= 16'h0000;
    end else begin
      exec_q <= 1'b0;
      if (run_q || phase_q != PH_FIRST) begin
        phase_q <= phase_q + 2'h1; // RL1
      end
      if (exec_q && br) begin
        pc_q <= pc_q + {{8{a2_q[7]}}, a2_q};
      end else if (mc_end && fetch_need) begin
        pc_q <= pc_q + 16'h0001;
      end
      if (mc_end) begin
        unique case (st_q)
          ST_OPC: begin
            op_q <= code_data;
            bytes_left_q <= len[4:3] - 2'h1;
            mc_left_q <= len[2:0] - 3'h1;
            idx_q <= 1'b0;
            if (len[2:0] == 3'h1) begin
              exec_q <= 1'b1;
            end else begin
              st_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (bytes_left_q != 2'h0) begin
              if (!idx_q) begin
                a1_q <= code_data;
              end else begin
                a2_q <= code_data;
              end
              idx_q <= 1'b1;
              bytes_left_q <= bytes_left_q - 2'h1;
            end
            mc_left_q <= mc_left_q - 3'h1;
            if (mc_left_q == 3'h1) begin
              exec_q <= 1'b1;
              st_q <= ST_OPC;
            end
          end
        endcase
      end
    end
  end

  // instruction execution
  always_comb begin
    s9 = 9'h000;
    lo5 = 5'h00;
    prod = 16'h0000;
    lhs = ZERO8;
    rhs = ZERO8;
    cin = 1'b0;
    acc_d = acc_q;
    b_d = b_q;
    psw_d = psw_q;
    br = 1'b0;
    rw_en = 1'b0;
    case (op_q) // RL3
      OP_INCA: acc_d = acc_q + 8'h01; // RL4
      OP_DECA: acc_d = acc_q - 8'h01; // RL4
      OP_ADDI, OP_ADDCI: begin
        cin = op_q == OP_ADDCI && psw_q[PSW_CY];
        s9 = {1'b0, acc_q} + {1'b0, a1_q} + {8'h00, cin};
        lo5 = {1'b0, acc_q[3:0]} + {1'b0, a1_q[3:0]} + {4'h0, cin};
        acc_d = s9[7:0];
        psw_d[PSW_CY] = s9[8]; // RL5
        psw_d[PSW_AC] = lo5[4];
        psw_d[PSW_OV] = acc_q[7] == a1_q[7] && s9[7] != acc_q[7];
      end
      OP_SUBBI: begin
        cin = psw_q[PSW_CY];
        s9 = {1'b0, acc_q} - {1'b0, a1_q} - {8'h00, cin};
        lo5 = {1'b0, acc_q[3:0]} - {1'b0, a1_q[3:0]} - {4'h0, cin};
        acc_d = s9[7:0];
        psw_d[PSW_CY] = s9[8]; // RL5
        psw_d[PSW_AC] = lo5[4];
        psw_d[PSW_OV] = acc_q[7] != a1_q[7] && s9[7] != acc_q[7];
      end
      OP_MUL: begin
        prod = acc_q * b_q;
        acc_d = prod[7:0];
        b_d = prod[15:8];
        psw_d[PSW_CY] = 1'b0; // RL6
        psw_d[PSW_OV] = |prod[15:8];
      end
      OP_DIV: begin
        psw_d[PSW_CY] = 1'b0; // RL6
        psw_d[PSW_OV] = b_q == ZERO8;
        if (b_q != ZERO8) begin
          acc_d = acc_q / b_q;
          b_d = acc_q % b_q;
        end
      end
      OP_DA: begin
        s9 = {1'b0, acc_q};
        if (acc_q[3:0] > BCD_MAX || psw_q[PSW_AC]) begin
          s9 = s9 + DA_LO;
        end
        if (s9[7:4] > BCD_MAX || s9[8] || psw_q[PSW_CY]) begin
          s9 = s9 + DA_HI;
        end
        acc_d = s9[7:0];
        psw_d[PSW_CY] = psw_q[PSW_CY] | s9[8]; // RL5
      end
      OP_RRC: begin
        acc_d = {psw_q[PSW_CY], acc_q[7:1]};
        psw_d[PSW_CY] = acc_q[0]; // RL5
      end
      OP_RLC: begin
        acc_d = {acc_q[6:0], psw_q[PSW_CY]};
        psw_d[PSW_CY] = acc_q[7]; // RL5
      end
      OP_CPLC: psw_d[PSW_CY] = !psw_q[PSW_CY]; // RL5
      OP_SETBC: psw_d[PSW_CY] = 1'b1; // RL6
      OP_CLRC: psw_d[PSW_CY] = 1'b0; // RL6
      OP_MOVAI: acc_d = a1_q;
      default: begin
        if (op_q >= OP_COMPARE_JUMP_NOT_EQUAL_AI && op_q <= OP_COMPARE_JUMP_NOT_EQUAL_HI) begin
          if (op_q <= OP_COMPARE_JUMP_NOT_EQUAL_AD) begin
            lhs = acc_q;
          end else if (op_q[3]) begin
            lhs = r_q[op_q[2:0]];
          end else begin
            lhs = r_q[r_q[{2'h0, op_q[0]}][2:0]];
          end
          rhs = op_q == OP_COMPARE_JUMP_NOT_EQUAL_AD ? r_q[a1_q[2:0]] : a1_q;
          psw_d[PSW_CY] = lhs < rhs; // RL5
          br = lhs != rhs;
        end else if (op_q[7:3] == OP_MOVRI[7:3]) begin
          rw_en = 1'b1;
        end else if (op_q[7:3] == OP_MOVAR[7:3]) begin
          acc_d = r_q[op_q[2:0]];
        end
      end
    endcase
    psw_d[0] = ^acc_d;
  end

  // accumulators, status word, stack pointer, data pointers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_q <= ZERO8;
      b_q <= ZERO8;
      psw_q <= ZERO8;
      sp_q <= SP_RST;
      for (int i = 0; i < 4; i++) begin
        dp_q[i] <= ZERO8;
      end
    end else if (sreset) begin
      acc_q <= ZERO8; // RL8
      b_q <= ZERO8;
      psw_q <= ZERO8;
      sp_q <= SP_RST;
      for (int i = 0; i < 4; i++) begin
        dp_q[i] <= ZERO8; // RL9
      end
    end else if (exec_q) begin
      acc_q <= acc_d;
      b_q <= b_d;
      psw_q <= psw_d;
    end
  end

  // working registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        r_q[i] <= ZERO8;
      end
    end else if (sreset) begin
      for (int i = 0; i < 8; i++) begin
        r_q[i] <= ZERO8;
      end
    end else if (exec_q && rw_en) begin
      r_q[op_q[2:0]] <= a1_q;
    end
  end

  assign wr = psel && penable && pwrite;

  // port latches and directions
  for (genvar k = 0; k < NPORT; k++) begin : g_port
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        port_q[k] <= PORT_RST;
        dir_q[k] <= PORT_RST;
      end else if (sreset) begin
        port_q[k] <= PORT_RST; // RL10
        dir_q[k] <= PORT_RST;
      end else if (wr && paddr[1:0] == ALIGN0 && paddr[4:2] == 3'(k)) begin
        if (paddr[7:5] == RGN_PORT) begin
          port_q[k] <= pwdata[7:0];
        end
        if (paddr[7:5] == RGN_DIR) begin
          dir_q[k] <= pwdata[7:0];
        end
      end
    end
  end

  // status, interrupt, clock, serial, caller-id registers (all 00h)
  for (genvar m = 0; m < NMISC; m++) begin : g_misc
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        misc_q[m] <= ZERO8;
      end else if (sreset) begin
        misc_q[m] <= ZERO8; // RL11 RL12 RL13
      end else if (wr && paddr[7:6] == RGN_MISC && paddr[5:2] == 4'(m) && paddr[1:0] == ALIGN0) begin
        misc_q[m] <= pwdata[7:0];
      end
    end
  end

  // data-pointer select and run control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dps_q <= ZERO8;
      run_q <= 1'b1;
    end else if (sreset) begin
      dps_q <= ZERO8; // RL9
      run_q <= 1'b1;
    end else if (wr) begin
      if (paddr == OFF_DPS) begin
        dps_q <= pwdata[7:0];
      end
      if (paddr == OFF_CTRL) begin
        run_q <= pwdata[0];
      end
    end
  end

  // reset-source dependent registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pmr_q <= PMR_HARD;
      watchdog_control_reg_q <= WD_POR_VAL; // RL18
    end else if (wdt_rst_req) begin
      pmr_q <= (pmr_q & PMR_WDT_KEEP) | PMR_WDT_SET; // RL16
      watchdog_control_reg_q <= (watchdog_control_reg_q & WD_WDT_KEEP) | WD_WDT_SET; // RL17
    end else if (ext_rst_req) begin
      pmr_q <= PMR_HARD; // RL15
      watchdog_control_reg_q <= watchdog_control_reg_q & WD_EXT_KEEP; // RL17
    end else if (wr) begin
      if (paddr == OFF_PMR) begin
        pmr_q <= pwdata[7:0];
      end
      if (paddr == OFF_WDCTL) begin
        watchdog_control_reg_q <= pwdata[7:0];
      end
    end
  end

  // apb read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    if (paddr[1:0] != ALIGN0) begin
      rd_hit = 1'b0;
    end else if (paddr[7:5] == RGN_PORT && paddr[4:2] < NPORT_IDX) begin
      rd_val = {8'h00, port_q[paddr[4:2]]};
    end else if (paddr[7:5] == RGN_DIR && paddr[4:2] < NPORT_IDX) begin
      rd_val = {8'h00, dir_q[paddr[4:2]]};
    end else if (paddr[7:6] == RGN_MISC) begin
      rd_val = {8'h00, misc_q[paddr[5:2]]};
    end else begin
      case (paddr)
        OFF_ACC: rd_val = {8'h00, acc_q};
        OFF_B: rd_val = {8'h00, b_q};
        OFF_PSW: rd_val = {8'h00, psw_q};
        OFF_SP: rd_val = {8'h00, sp_q};
        OFF_DP0L: rd_val = {8'h00, dp_q[0]};
        OFF_DP0H: rd_val = {8'h00, dp_q[1]};
        OFF_DP1L: rd_val = {8'h00, dp_q[2]};
        OFF_DP1H: rd_val = {8'h00, dp_q[3]};
        OFF_DPS: rd_val = {8'h00, dps_q};
        OFF_PMR: rd_val = {8'h00, pmr_q};
        OFF_WDCTL: rd_val = {8'h00, watchdog_control_reg_q};
        OFF_FSK: rd_val = {8'h00, fsk_detect}; // RL14
        OFF_TONE: rd_val = {8'h00, tone_detect}; // RL14
        OFF_CTRL: rd_val = {15'h0000, run_q};
        OFF_PC: rd_val = pc_q;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_q <= 16'h0000;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      rd_q <= pwrite ? 16'h0000 : rd_val;
      err_q <= !rd_hit;
    end
  end
  assign prdata = {16'h0000, rd_q};
  assign pready = psel && penable;
  assign pslverr = psel && penable && err_q;

  // clocks since opcode capture, for timing checks
  logic [7:0] since_op_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_op_q <= 8'h00;
    end else if (mc_end && st_q == ST_OPC) begin
      since_op_q <= 8'h00;
    end else if (since_op_q != 8'hff) begin
      since_op_q <= since_op_q + 8'h01;
    end
  end
  // execute cycle is phase 0 of the fifth machine cycle, 12 edges after capture
  localparam logic [7:0] COMPARE_JUMP_NOT_EQUAL_CLKS = 8'(4 * PH_PER_MC - 4);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  phase_wrap_a: // RL1
    assert property (mc_end && !sreset ##1 run_q && !sreset |-> phase_q == PH_FIRST ##1 phase_q == PH_FETCH)
      else $error("machine cycle is not four clocks");
  one_fetch_a: // RL2
    assert property (code_rd && !sreset ##1 !sreset |-> !code_rd [*3])
      else $error("more than one fetch per machine cycle");
  incdec_flags_a: // RL4
    assert property (exec_q && !sreset && (op_q == OP_INCA || op_q == OP_DECA)
      |=> psw_q[7:6] == $past(psw_q[7:6]) && psw_q[PSW_OV] == $past(psw_q[PSW_OV]))
      else $error("inc or dec changed flags");
  add_carry_a: // RL5
    assert property (exec_q && !sreset && op_q == OP_ADDI
      |=> {psw_q[PSW_CY], acc_q} == {1'b0, $past(acc_q)} + {1'b0, $past(a1_q)})
      else $error("add result or carry wrong");
  mul_flags_a: // RL6
    assert property (exec_q && !sreset && op_q == OP_MUL
      |=> !psw_q[PSW_CY] && psw_q[PSW_OV] == (b_q != ZERO8))
      else $error("mul flags wrong");
  compare_jump_not_equal_timing_a: // RL7
    assert property (exec_q && op_q >= OP_COMPARE_JUMP_NOT_EQUAL_AI && op_q <= OP_COMPARE_JUMP_NOT_EQUAL_HI |-> since_op_q == COMPARE_JUMP_NOT_EQUAL_CLKS)
      else $error("compare-jump did not take four machine cycles");
  core_reset_a: // RL8
    assert property (sreset |=> acc_q == ZERO8 && b_q == ZERO8 && psw_q == ZERO8 && sp_q == SP_RST)
      else $error("core registers wrong after reset");
  port_reset_a: // RL10
    assert property (sreset |=> port_q[0] == PORT_RST && dir_q[NPORT-1] == PORT_RST)
      else $error("port registers wrong after reset");
  detect_read_a: // RL14
    assert property (psel && !penable && !pwrite && paddr == OFF_FSK |=> prdata[7:0] == $past(fsk_detect))
      else $error("fsk data not live");
  pmr_wdt_a: // RL16
    assert property (wdt_rst_req |=> pmr_q[7:5] == $past(pmr_q[7:5]) && pmr_q[4:0] == PMR_WDT_SET[4:0])
      else $error("power register wrong after watchdog reset");
  watchdog_reset_flag_ext_a: // RL17
    assert property (ext_rst_req && !wdt_rst_req
      |=> watchdog_control_reg_q[WD_WATCHDOG_RESET_FLAG] == $past(watchdog_control_reg_q[WD_WATCHDOG_RESET_FLAG]) && watchdog_control_reg_q[WD_EWT] == $past(watchdog_control_reg_q[WD_EWT]))
      else $error("external reset altered watchdog flags");
endmodule
`default_nettype wire

/* rtl/cts_pkg.sv */
// constants shared by the core timing and reset-state block
// assumes a single 10 MHz clock and a 32-bit apb register bus
package cts_pkg;
  // machine cycle phases, one clock each, four per machine cycle
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_FETCH = 2'h1;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam int PH_PER_MC = 4;
  // instruction length codes {bytes[1:0], machine cycles[2:0]}
  localparam logic [4:0] LEN_1_1 = {2'h1, 3'h1};
  localparam logic [4:0] LEN_2_2 = {2'h2, 3'h2};
  localparam logic [4:0] LEN_1_5 = {2'h1, 3'h5};
  localparam logic [4:0] LEN_3_4 = {2'h3, 3'h4};
  // opcodes
  localparam logic [7:0] OP_INCA = 8'h04;
  localparam logic [7:0] OP_DECA = 8'h14;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_ADDI = 8'h24;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_ADDCI = 8'h34;
  localparam logic [7:0] OP_MOVAI = 8'h74;
  localparam logic [7:0] OP_MOVRI = 8'h78;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_SUBBI = 8'h94;
  localparam logic [7:0] OP_MUL = 8'ha4;
  localparam logic [7:0] OP_CPLC = 8'hb3;
  localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_AI = 8'hb4;
  localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_AD = 8'hb5;
  localparam logic [7:0] OP_COMPARE_JUMP_NOT_EQUAL_HI = 8'hbf;
  localparam logic [7:0] OP_CLRC = 8'hc3;
  localparam logic [7:0] OP_SETBC = 8'hd3;
  localparam logic [7:0] OP_DA = 8'hd4;
  localparam logic [7:0] OP_MOVAR = 8'he8;
  // decimal adjust constants
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] DA_LO = 9'h006;
  localparam logic [8:0] DA_HI = 9'h060;
  // program status word bits
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_OV = 2;
  // watchdog control bits
  localparam int WD_POR = 6;
  localparam int WD_WATCHDOG_RESET_FLAG = 2;
  localparam int WD_EWT = 1;
  // reset values
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] PMR_HARD = 8'h81;
  localparam logic [7:0] PMR_WDT_KEEP = 8'he0;
  localparam logic [7:0] PMR_WDT_SET = 8'h01;
  localparam logic [7:0] WD_POR_VAL = 8'h40;
  localparam logic [7:0] WD_EXT_KEEP = 8'h46;
  localparam logic [7:0] WD_WDT_KEEP = 8'h42;
  localparam logic [7:0] WD_WDT_SET = 8'h04;
  // sizes
  localparam int NPORT = 5;
  localparam logic [2:0] NPORT_IDX = 3'h5;
  localparam int NMISC = 16;
  // apb byte offsets
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_B = 8'h04;
  localparam logic [7:0] OFF_PSW = 8'h08;
  localparam logic [7:0] OFF_SP = 8'h0c;
  localparam logic [7:0] OFF_DP0L = 8'h10;
  localparam logic [7:0] OFF_DP0H = 8'h14;
  localparam logic [7:0] OFF_DP1L = 8'h18;
  localparam logic [7:0] OFF_DP1H = 8'h1c;
  localparam logic [7:0] OFF_DPS = 8'h20;
  localparam logic [7:0] OFF_PMR = 8'h24;
  localparam logic [7:0] OFF_WDCTL = 8'h28;
  localparam logic [7:0] OFF_FSK = 8'h2c;
  localparam logic [7:0] OFF_TONE = 8'h30;
  localparam logic [7:0] OFF_CTRL = 8'h34;
  localparam logic [7:0] OFF_PC = 8'h38;
  localparam logic [2:0] RGN_PORT = 3'h2;
  localparam logic [2:0] RGN_DIR = 3'h3;
  localparam logic [1:0] RGN_MISC = 2'h2;
  localparam logic [1:0] ALIGN0 = 2'h0;
  typedef enum logic [1:0] {
    ST_OPC = 2'b01,
    ST_RUN = 2'b10
  } cts_state_t;
endpackage

/* verification/cts_code_mem.sv */
// program memory model feeding the core's code fetch port
// assumes the fetch contract: byte needed from the cycle after code_rd
// until the phase-3 edge, nothing promised outside that span
`timescale 1ns/1ps
`default_nettype none
module cts_code_mem (
  // clock
  input wire logic clk,
  // fetch port
  input wire logic [15:0] code_addr,
  input wire logic code_rd,
  output logic [7:0] code_data
);
  logic [7:0] mem [256];
  logic [1:0] hold_q;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    code_data = 8'h00;
    hold_q = 2'h0;
  end
  // data held two edges, then inverted on every later edge, so a stale byte is wrong on alternate clocks
  always @(posedge clk) begin
    if (code_rd === 1'b1) begin
      code_data <= mem[code_addr[7:0]];
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      code_data <= ~code_data;
    end
  end
endmodule
`default_nettype wire

/* verification/test_cpu_core_timing_reset_state.sv */
// self-checking bench for the core timing and reset-state block
// assumes apb with zero wait states and the code memory model beside it
`timescale 1ns/1ps
`default_nettype none
module test_cpu_core_timing_reset_state;
  import cts_pkg::*;
  logic clk, reset, ext_rst_req, wdt_rst_req, code_rd, psel, penable, pwrite, pready, pslverr;
  logic [15:0] code_addr;
  logic [7:0] code_data, fsk_detect, tone_detect, paddr, pm_w, wd_w;
  logic [NPORT-1:0][7:0] port_latch, port_dir;
  logic [31:0] pwdata, prdata, dummy;
  int bad_count, check_count, cyc, last, lastj, jcount;
  cts_core i_dut (.clk(clk), .reset(reset), .ext_rst_req(ext_rst_req), .wdt_rst_req(wdt_rst_req),
    .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data), .fsk_detect(fsk_detect),
    .tone_detect(tone_detect), .port_latch(port_latch), .port_dir(port_dir), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  cts_code_mem i_mem (.clk(clk), .code_addr(code_addr), .code_rd(code_rd), .code_data(code_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic close_out();
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_gap(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("Error %0t: timing %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic check_all(input logic [7:0] pm, input logic [7:0] wd);
    for (int i = 0; i < 3; i++) rd(8'(4 * i), 32'h0);
    rd(OFF_SP, 32'h07);
    for (int i = 4; i < 9; i++) rd(8'(4 * i), 32'h0);
    rd(OFF_PMR, {24'h0, pm});
    rd(OFF_WDCTL, {24'h0, wd});
    for (int i = 0; i < NPORT; i++) begin
      rd(8'(8'h40 + 4 * i), 32'hff);
      rd(8'(8'h60 + 4 * i), 32'hff);
      chk({24'h0, port_latch[i]}, 32'hff);
    end
    for (int i = 0; i < NMISC; i++) rd(8'(8'h80 + 4 * i), 32'h0);
  endtask
  // random contents in the select, power, watchdog, port and misc registers so a reset that misses one shows
  task automatic scramble();
    pm_w = 8'($urandom);
    wd_w = 8'($urandom);
    wr(OFF_DPS, $urandom);
    wr(OFF_PMR, {24'h0, pm_w});
    wr(OFF_WDCTL, {24'h0, wd_w});
    for (int i = 0; i < NPORT; i++) begin
      wr(8'(8'h40 + 4 * i), $urandom);
      wr(8'(8'h60 + 4 * i), $urandom);
    end
    for (int i = 0; i < NMISC; i++) wr(8'(8'h80 + 4 * i), $urandom);
  endtask
  task automatic pulse(input logic wdt);
    @(posedge clk);
    if (wdt) wdt_rst_req <= 1'b1;
    else ext_rst_req <= 1'b1;
    @(posedge clk);
    wdt_rst_req <= 1'b0;
    ext_rst_req <= 1'b0;
  endtask
  // {acc, psw} after carry op, arith, inc, dec, then the compare loop
  function automatic logic [15:0] alu(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                                      input logic c);
    logic [8:0] r;
    logic ac, ov;
    if (op == OP_SUBBI) begin
      r = {1'b0, a} - {1'b0, b} - {8'h0, c};
      ac = {1'b0, a[3:0]} < {1'b0, b[3:0]} + {4'h0, c};
      ov = (a[7] != b[7]) && (r[7] != a[7]);
    end else begin
      r = {1'b0, a} + {1'b0, b} + {8'h0, c && op == OP_ADDCI};
      ac = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c && op == OP_ADDCI}) > 5'hf;
      ov = (a[7] == b[7]) && (r[7] != a[7]);
    end
    return {r[7:0], ~r[7], ac, 3'h0, ov, 1'b0, ^r[7:0]};
  endfunction
  task automatic prog(input logic [7:0] op, input logic cin);
    logic [7:0] a, b;
    logic [15:0] x;
    logic [79:0] p;
    int n;
    a = 8'($urandom);
    b = 8'($urandom);
    x = alu(op, a, b, cin);
    p = {cin ? OP_SETBC : OP_CLRC, OP_MOVAI, a, op, b, OP_INCA, OP_DECA, OP_COMPARE_JUMP_NOT_EQUAL_AI, ~x[15:8], 8'hfd};
    for (n = 0; n < 10; n++) i_mem.mem[n] = p[79 - 8 * n -: 8];
    pulse(1'b0);
    jcount = 0;
    n = 0;
    while (jcount < 2 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk_gap(jcount >= 2, 1);
    rd(OFF_ACC, {24'h0, x[15:8]});
    rd(OFF_PSW, {24'h0, x[7:0]});
  endtask
  // fetch spacing and compare-loop period
  always @(posedge clk) begin
    cyc++;
    if (reset || ext_rst_req || wdt_rst_req) begin
      last = -1;
      lastj = -1;
      jcount = 0;
    end else if (code_rd === 1'b1) begin
      if (last >= 0) chk_gap(cyc - last >= 4 && (cyc - last) % 4 == 0, 1);
      last = cyc;
      if (code_addr === 16'h0007) begin
        if (lastj >= 0) chk_gap(cyc - lastj, 16);
        lastj = cyc;
        jcount++;
      end
    end
  end
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  initial begin
    logic [31:0] r;
    logic e;
    dummy = $urandom(32'hf40b6fa6);
    {reset, ext_rst_req, wdt_rst_req, psel, penable, pwrite} = 6'h20;
    {paddr, pwdata, fsk_detect, tone_detect} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    check_all(8'h81, 8'h40);
    repeat (2) begin
      fsk_detect <= 8'($urandom);
      tone_detect <= 8'($urandom);
      @(posedge clk);
      rd(OFF_FSK, {24'h0, fsk_detect});
      rd(OFF_TONE, {24'h0, tone_detect});
    end
    scramble();
    pulse(1'b0);
    check_all(8'h81, wd_w & 8'h46);
    scramble();
    pulse(1'b1);
    check_all((pm_w & 8'he0) | 8'h01, (wd_w & 8'h42) | 8'h04);
    // unmapped and unaligned accesses are refused
    apb(1'b0, 8'hc0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h05, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 6; i++) prog(i % 3 == 0 ? OP_ADDI : i % 3 == 1 ? OP_ADDCI : OP_SUBBI, i < 3);
    close_out();
  end
endmodule
`default_nettype wire
